// ### rtl/lut_interp_div.sv
// lookup-table profile block: restoring divider for segment interpolation
// assumes a start pulse only while idle; den of zero is screened by caller
`timescale 1ns/1ps
`default_nettype none

module lut_interp_div #(
   parameter int NW = 36,
   parameter int DW = 20
) (
   input  wire logic          mclk,
   input  wire logic          rst_n,
   input  wire logic          start,
   input  wire logic [NW-1:0] num,
   input  wire logic [DW-1:0] den,
   output logic      [NW-1:0] quo_q,
   output logic               done_q
);

   localparam int CW = $clog2(NW + 1);

   logic [DW:0]   rem_q;
   logic [DW-1:0] den_q;
   logic [CW-1:0] cnt_q;
   logic          busy_q;

   wire  [DW:0]   shifted = {rem_q[DW-1:0], quo_q[NW-1]};
   wire           fits    = shifted >= {1'b0, den_q};
   wire  [DW:0]   rem_nx  = fits ? shifted - {1'b0, den_q} : shifted;

   // quotient bits shift in where the dividend shifts out
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         quo_q  <= '0;
         rem_q  <= '0;
         den_q  <= '0;
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (start) begin
         quo_q  <= num;
         rem_q  <= '0;
         den_q  <= den;
         cnt_q  <= CW'(NW);
         busy_q <= 1'b1;
         done_q <= 1'b0;
      end else if (busy_q) begin
         quo_q  <= {quo_q[NW-2:0], fits};
         rem_q  <= rem_nx;
         cnt_q  <= cnt_q - 1'b1;
         busy_q <= cnt_q != CW'(1);
         done_q <= cnt_q == CW'(1);
      end else begin
         done_q <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ### rtl/lut_map.svh
// lookup-table profile block: timing, sizing and default constants
// assumes a 200 MHz mclk; included by the package, lut_profile and the bench files
`ifndef LUT_MAP_SVH
`define LUT_MAP_SVH

`define LUT_NPTS        11
`define LUT_LAST        4'hA
`define LUT_IDX_W       4
`define LUT_XW          20
`define LUT_YW          16
`define LUT_SRC_W       4
`define LUT_SRC_NONE    4'h0
`define LUT_Y_FULL      16'h03E8
`define LUT_X_RST       20'h00000
`define LUT_Y_RST       16'h0000
`define LUT_CLK_MHZ     200
`define LUT_TICK_MS     1
`define LUT_TICK_CYC    (`LUT_TICK_MS * `LUT_CLK_MHZ * 1000)
`define LUT_IVL_MIN_MS  1
`define LUT_IVL_MAX_MS  60000

`endif

// ### rtl/lut_pkg.sv
// lookup-table profile block: shared types
// assumes lut_map.svh is on the include path
`include "lut_map.svh"

package lut_pkg;

   typedef enum logic [1:0] {shape_linear, shape_step, shape_ignore} lut_shape_t;

   typedef enum logic [1:0] {st_samp, st_seek, st_div} lut_state_t;

   typedef struct packed {
      logic                  we;
      logic [`LUT_IDX_W-1:0] idx;
      logic [`LUT_XW-1:0]    x;
      logic [`LUT_YW-1:0]    y;
      lut_shape_t            shape;
   } lut_pt_wr_t;

   typedef struct packed {
      logic [`LUT_YW-1:0] floor_v;
      logic [`LUT_YW-1:0] ceil_v;
   } lut_lim_t;

endpackage

// ### rtl/lut_profile.sv
// lookup-table profile block: eleven-point table, data or time driven
// assumes config ports synchronous to mclk; src limits come from the source
`timescale 1ns/1ps
`default_nettype none
`include "lut_map.svh"

module lut_profile
   import lut_pkg::*;
#(
   parameter int MS_CYC = `LUT_TICK_CYC
) (
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic [`LUT_SRC_W-1:0] x_src_sel,
   input  wire logic                  time_mode,
   input  wire logic                  auto_cycle,
   input  wire logic [`LUT_XW-1:0]    src_data,
   input  wire logic [`LUT_XW-1:0]    src_min,
   input  wire logic [`LUT_XW-1:0]    src_max,
   input  wire lut_pt_wr_t            pt_wr,
   output lut_lim_t                   lim_q,
   output logic      [`LUT_YW-1:0]    lut_out_q,
   output logic                       table_en_q,
   output logic                       profile_done_q
);

   localparam int NP  = `LUT_NPTS;
   localparam int XW  = `LUT_XW;
   localparam int YW  = `LUT_YW;
   localparam int NW  = XW + YW;
   localparam int MSW = $clog2(MS_CYC + 1);

   // ==========================================================
   // reset release
   logic [1:0] rst_s_q;
   wire        rst_n = rst_s_q[1];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s_q <= 2'h0;
      end else begin
         rst_s_q <= {rst_s_q[0], 1'b1};
      end
   end

   // ==========================================================
   // table storage and defaults
   logic [XW-1:0]         pt_x_q [NP];
   logic [YW-1:0]         pt_y_q [NP];
   lut_shape_t            pt_shape_q [NP];
   logic [`LUT_SRC_W-1:0] src_prev_q;
   logic [NP-1:0]         act;
   logic [XW-1:0]         xs_q;

   wire           table_en  = x_src_sel != `LUT_SRC_NONE;
   wire           load_dflt = table_en && (x_src_sel != src_prev_q);
   wire [XW-1:0]  span      = src_max - src_min;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_q <= `LUT_SRC_NONE;
      end else begin
         src_prev_q <= x_src_sel;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_pt
         // even spacing: x across source range, y across 0..100 percent
         wire [XW-1:0] dflt_x = src_min + XW'((32'(span) * 32'(gi)) / 32'h0000000A);
         wire [YW-1:0] dflt_y = YW'((32'(`LUT_Y_FULL) * 32'(gi)) / 32'h0000000A);
         wire          wr_hit = pt_wr.we && (pt_wr.idx == `LUT_IDX_W'(gi));

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               pt_x_q[gi]     <= `LUT_X_RST;
               pt_y_q[gi]     <= `LUT_Y_RST;
               pt_shape_q[gi] <= shape_linear;
            end else if (load_dflt) begin
               pt_x_q[gi]     <= dflt_x;
               pt_y_q[gi]     <= dflt_y;
               pt_shape_q[gi] <= shape_linear;
            end else if (wr_hit) begin
               pt_x_q[gi]     <= pt_wr.x;
               pt_y_q[gi]     <= pt_wr.y;
               // origin can never be ignored
               pt_shape_q[gi] <= (gi == 0) ? shape_linear : pt_wr.shape;
            end
         end

         // one ignored point cuts off everything above it
         if (gi == 0) begin : g_org
            assign act[gi] = 1'b1;
         end else begin : g_rest
            assign act[gi] = act[gi-1] && (pt_shape_q[gi] != shape_ignore);
         end
      end
   endgenerate

   // ==========================================================
   // limits, last active point, segment search
   logic [YW-1:0]         y_min;
   logic [YW-1:0]         y_max;
   logic [`LUT_IDX_W-1:0] last_idx;
   logic [`LUT_IDX_W-1:0] seg;
   logic                  found;

   always_comb begin
      y_min    = pt_y_q[0];
      y_max    = pt_y_q[0];
      last_idx = '0;
      seg      = '0;
      found    = 1'b0;
      for (int i = 1; i < NP; i++) begin
         if (act[i]) begin
            last_idx = `LUT_IDX_W'(i);
            if (pt_y_q[i] < y_min) y_min = pt_y_q[i];
            if (pt_y_q[i] > y_max) y_max = pt_y_q[i];
            if (!found && (xs_q <= pt_x_q[i])) begin
               seg   = `LUT_IDX_W'(i);
               found = 1'b1;
            end
         end
      end
   end

   // seg is zero only on the direct path; keep the lower index inside the table
   wire [`LUT_IDX_W-1:0] seg_lo = (seg == '0) ? '0 : seg - 1'b1;
   wire [XW-1:0] x_end = pt_x_q[last_idx];
   wire [YW-1:0] y_end = pt_y_q[last_idx];
   wire [XW-1:0] x_lo  = pt_x_q[seg_lo];
   wire [XW-1:0] x_hi  = pt_x_q[seg];
   wire [YW-1:0] y_lo  = pt_y_q[seg_lo];
   wire [YW-1:0] y_hi  = pt_y_q[seg];
   wire [XW-1:0] dx    = x_hi - x_lo;
   wire [XW-1:0] dxo   = xs_q - x_lo;
   wire          up    = y_hi >= y_lo;
   wire [YW-1:0] dy    = up ? y_hi - y_lo : y_lo - y_hi;

   // below origin, past the end, step, or zero-width segment need no divide
   wire          below0 = xs_q <= pt_x_q[0];
   wire          direct = below0 || !found || (pt_shape_q[seg] == shape_step) || (dx == '0);
   wire [YW-1:0] direct_y = below0 ? pt_y_q[0] :
                            !found ? pt_y_q[last_idx] :
                            y_hi;

   // ==========================================================
   // time base: millisecond enable and elapsed time
   logic [MSW-1:0] ms_cnt_q;
   logic [XW-1:0]  elapsed_q;
   logic           on_q;

   // analog sources count as on when nonzero
   wire ctl_on   = src_data != '0;
   wire run      = table_en && time_mode && ctl_on;
   wire ctl_rise = ctl_on && !on_q;
   wire ms_tick  = run && (ms_cnt_q == MSW'(MS_CYC - 1));
   wire at_end   = elapsed_q >= x_end;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         on_q      <= 1'b0;
         ms_cnt_q  <= '0;
         elapsed_q <= '0;
      end else begin
         on_q <= ctl_on;
         if (!run || ctl_rise) begin
            ms_cnt_q  <= '0;
            elapsed_q <= '0;
         end else begin
            ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
            if (ms_tick && at_end) begin
               elapsed_q <= auto_cycle ? pt_x_q[0] : elapsed_q;
            end else if (ms_tick) begin
               // 20 bits cover ten intervals of up to 60000 ms
               elapsed_q <= elapsed_q + 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // evaluation sequencer
   lut_state_t    state_q;
   logic [YW-1:0] res_q;
   logic          res_vld_q;
   logic [YW-1:0] ybase_q;
   logic          up_q;
   logic          div_start;
   logic [NW-1:0] div_quo;
   logic          div_done;

   assign div_start = (state_q == st_seek) && !direct;

   wire [NW-1:0] prod   = NW'(dy) * NW'(dxo);
   wire [YW-1:0] quo_y  = div_quo[YW-1:0];
   wire [YW-1:0] interp = up_q ? ybase_q + quo_y : ybase_q - quo_y;

   lut_interp_div #(.NW(NW), .DW(XW)) u_div (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .start  (div_start),
      .num    (prod),
      .den    (dx),
      .quo_q  (div_quo),
      .done_q (div_done)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= st_samp;
         xs_q      <= '0;
         res_q     <= '0;
         res_vld_q <= 1'b0;
         ybase_q   <= '0;
         up_q      <= 1'b0;
      end else begin
         res_vld_q <= 1'b0;
         unique case (state_q)
            st_samp: begin
               xs_q    <= time_mode ? elapsed_q : src_data;
               state_q <= st_seek;
            end
            st_seek: begin
               ybase_q <= y_lo;
               up_q    <= up;
               if (direct) begin
                  res_q     <= direct_y;
                  res_vld_q <= 1'b1;
                  state_q   <= st_samp;
               end else begin
                  state_q <= st_div;
               end
            end
            st_div: begin
               if (div_done) begin
                  res_q     <= interp;
                  res_vld_q <= 1'b1;
                  state_q   <= st_samp;
               end
            end
            default: state_q <= st_samp;
         endcase
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lut_out_q      <= '0;
         lim_q          <= '0;
         table_en_q     <= 1'b0;
         profile_done_q <= 1'b0;
      end else begin
         table_en_q     <= table_en;
         profile_done_q <= run && at_end && !auto_cycle;
         lim_q.floor_v  <= table_en ? y_min : '0;
         lim_q.ceil_v   <= table_en ? y_max : '0;
         if (!table_en || (time_mode && !ctl_on)) begin
            lut_out_q <= '0;
         end else if (res_vld_q) begin
            lut_out_q <= res_q;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_div_run;
      div_start ##1 (state_q == st_div) [*3];
   endsequence

   a_div_bound: assert property (s_div_run |-> ##[1:40] res_vld_q)
      else $error("interpolation did not finish in time");
   a_off_zero: assert property (table_en && time_mode && !ctl_on |=> lut_out_q == '0)
      else $error("time output not zero while off");
   a_disabled_zero: assert property (!table_en |=> lut_out_q == '0 && lim_q == '0)
      else $error("disabled table drives nonzero");
   a_floor_ceil: assert property (table_en |=> lim_q.floor_v <= $past(y_end)
                                  && lim_q.ceil_v >= $past(y_end))
      else $error("limits exclude last active point");
   a_floor_org: assert property (table_en |=> lim_q.floor_v <= $past(pt_y_q[0])
                                 && lim_q.ceil_v >= $past(pt_y_q[0]))
      else $error("limits exclude origin point");
   a_restart_org: assert property (run && ctl_rise |=> elapsed_q == '0 ##1 elapsed_q == '0)
      else $error("profile did not restart at origin");
   a_hold_end: assert property (run && at_end && !auto_cycle ##1 run |-> $stable(elapsed_q))
      else $error("elapsed time moved after profile end");
   a_repeat_wrap: assert property (ms_tick && at_end && auto_cycle && !ctl_rise
                                   |=> elapsed_q == $past(pt_x_q[0]))
      else $error("repeat did not wrap to first segment");
   a_dflt_load: assert property (load_dflt |=> pt_y_q[0] == '0 && pt_y_q[10] == `LUT_Y_FULL
                                 && pt_shape_q[5] == shape_linear)
      else $error("defaults not loaded on source select");

endmodule
`default_nettype wire

// ### verif/lut_src_model.sv
// control source feeding the lookup table: value and range of the source
// assumes commands from the bench change at the falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
`include "lut_map.svh"

module lut_src_model (
   input  wire logic [`LUT_XW-1:0] cmd_val,
   input  wire logic [`LUT_XW-1:0] cmd_min,
   input  wire logic [`LUT_XW-1:0] cmd_max,
   input  wire logic               mclk,
   output logic      [`LUT_XW-1:0] src_data,
   output logic      [`LUT_XW-1:0] src_min,
   output logic      [`LUT_XW-1:0] src_max
);
   // ==========================================================
   // source outputs
   // one cycle of source latency, like a real upstream block
   // launched on the rising edge, so the bench's falling-edge commands never race it
   always_ff @(posedge mclk) begin
      src_data <= cmd_val;
      src_min  <= (cmd_min <= cmd_max) ? cmd_min : cmd_max;
      src_max  <= cmd_max;
   end
endmodule

`default_nettype wire

// ### verif/test_lut_profile.sv
// lookup-table profile block: self-checking bench
// assumes lut_profile and lut_src_model compiled first; mclk 200 MHz
`timescale 1ns/1ps
`default_nettype none
`include "lut_map.svh"

module test_lut_profile
   import lut_pkg::*;
   ();
   // short millisecond keeps the time profile within a few 10k cycles
   localparam int MS = 100;

   logic                mclk;
   logic                rst_b;
   logic [3:0]          x_src_sel;
   logic                time_mode;
   logic                auto_cycle;
   logic [`LUT_XW-1:0]  cmd_val;
   logic [`LUT_XW-1:0]  cmd_min;
   logic [`LUT_XW-1:0]  cmd_max;
   logic [`LUT_XW-1:0]  src_data;
   logic [`LUT_XW-1:0]  src_min;
   logic [`LUT_XW-1:0]  src_max;
   lut_pt_wr_t          pt_wr;
   lut_lim_t            lim_q;
   logic [`LUT_YW-1:0]  lut_out_q;
   logic [`LUT_YW-1:0]  prev;
   logic                table_en_q;
   logic                profile_done_q;
   logic                seen_drop;
   logic                done_seen;
   int                  n;
   int                  bad_count;
   int                  comparisons;

   lut_src_model SRC (
      .cmd_val  (cmd_val),
      .cmd_min  (cmd_min),
      .cmd_max  (cmd_max),
      .mclk     (mclk),
      .src_data (src_data),
      .src_min  (src_min),
      .src_max  (src_max)
   );

   lut_profile #(.MS_CYC(MS)) DUT (
      .mclk           (mclk),
      .rst_b          (rst_b),
      .x_src_sel      (x_src_sel),
      .time_mode      (time_mode),
      .auto_cycle     (auto_cycle),
      .src_data       (src_data),
      .src_min        (src_min),
      .src_max        (src_max),
      .pt_wr          (pt_wr),
      .lim_q          (lim_q),
      .lut_out_q      (lut_out_q),
      .table_en_q     (table_en_q),
      .profile_done_q (profile_done_q)
   );

   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask

   task automatic wr_pt(input logic [3:0] idx, input logic [19:0] x, input logic [15:0] y,
                        input lut_shape_t sh);
      pt_wr = '{we: 1'b1, idx: idx, x: x, y: y, shape: sh};
      @(negedge mclk);
      pt_wr.we = 1'b0;
      cyc(2);
   endtask

   // output must reach the value within 300 cycles
   task automatic settle(input logic [15:0] exp);
      int k;
      k = 0;
      while (lut_out_q !== exp && k < 300) begin
         @(negedge mclk);
         k++;
      end
      check(32'(lut_out_q), 32'(exp));
      if (lut_out_q !== exp) summarize();
   endtask

   // ==========================================================
   // clock and sequence
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      rst_b = 1'b0;
      x_src_sel = `LUT_SRC_NONE;
      time_mode = 1'b0;
      auto_cycle = 1'b0;
      cmd_val = 20'h00000;
      cmd_min = 20'h00000;
      cmd_max = 20'h003E8;
      pt_wr = '0;
      bad_count = 0;
      comparisons = 0;
      cyc(10);
      rst_b = 1'b1;
      cyc(4);
      check(32'(table_en_q), 32'h0);
      check(lim_q, 32'h0);
      // data mode, source range 0..1000
      x_src_sel = 4'h1;
      cyc(3);
      check(32'(table_en_q), 32'h1);
      check(lim_q, 32'h000003E8);
      cmd_val = 20'h000FA;
      settle(16'h00FA);
      wr_pt(4'h3, 20'h0012C, 16'h012C, shape_step);
      settle(16'h012C);
      wr_pt(4'h5, 20'h001F4, 16'h01F4, shape_ignore);
      check(lim_q, 32'h00000190);
      cmd_val = 20'h00384;
      settle(16'h0190);
      // origin cannot be ignored; Y out of order
      wr_pt(4'h0, 20'h00032, 16'h02BC, shape_ignore);
      check(lim_q, 32'h006402BC);
      cmd_val = 20'h00000;
      settle(16'h02BC);
      wr_pt(4'hB, 20'h00000, 16'hFFFF, shape_linear);
      check(lim_q, 32'h006402BC);
      x_src_sel = `LUT_SRC_NONE;
      cyc(3);
      check(32'(table_en_q), 32'h0);
      check(lim_q, 32'h0);
      // time mode, X 0..100 ms, Y 0..1000
      time_mode = 1'b1;
      cmd_max = 20'h00064;
      cyc(2);
      x_src_sel = 4'h2;
      cyc(3);
      settle(16'h0000);
      check(lim_q, 32'h000003E8);
      cmd_val = 20'h00001;
      n = 0;
      while (profile_done_q !== 1'b1 && n < 12000) begin
         @(negedge mclk);
         n++;
      end
      check(32'(n >= 9900 && n <= 10300), 32'h1);
      if (n >= 12000) summarize();
      settle(16'h03E8);
      cyc(500);
      check(32'(lut_out_q), 32'h03E8);
      check(32'(profile_done_q), 32'h1);
      cmd_val = 20'h00000;
      settle(16'h0000);
      cmd_val = 20'h00001;
      cyc(300);
      check(32'(lut_out_q > 16'h0000 && lut_out_q < 16'h0064), 32'h1);
      // repeat: the ramp must fall back and never report done
      auto_cycle = 1'b1;
      seen_drop = 1'b0;
      done_seen = 1'b0;
      prev = lut_out_q;
      repeat (25000) begin
         @(negedge mclk);
         if (lut_out_q < prev) seen_drop = 1'b1;
         if (profile_done_q !== 1'b0) done_seen = 1'b1;
         prev = lut_out_q;
      end
      check(32'(seen_drop), 32'h1);
      check(32'(done_seen), 32'h0);
      summarize();
   end
endmodule

`default_nettype wire
